// ---- src/irqrm_pkg.sv ----
package irqrm_pkg;

    // request lines and vector numbering
    localparam int NUM_LINES = 20;
    localparam int VECTOR_OFFSET = 16;
    localparam int NUM_SERIAL = 16;
    localparam int SERIAL_PAIR_STEP = 8;
    localparam int NUM_EXT_INT = 32;
    localparam int NUM_TIMER_UNITS = 3;
    localparam int NUM_DTQD = 3;
    localparam int NUM_SEL_FIELDS = 4;
    localparam int SEL_SRC_W = 32;

    // fixed exception vectors, no request line
    localparam int VEC_STACK_INIT = 0;
    localparam int VEC_RESET = 1;
    localparam int VEC_NMI_HW_WDOG = 2;
    localparam int VEC_HARD_FAULT = 3;
    localparam int VEC_MEM_MANAGE = 4;
    localparam int VEC_BUS_FAULT = 5;
    localparam int VEC_USAGE_FAULT = 6;
    localparam int VEC_SUPERVISOR_CALL = 11;
    localparam int VEC_DEBUG_MONITOR = 12;
    localparam int VEC_PENDABLE_SERVICE_CALL = 14;
    localparam int VEC_SYSTEM_TICK_TIMER = 15;

    // line positions, both modes
    localparam int LINE_CLK_ANOMALY = 0;
    localparam int LINE_SW_WDOG = 1;
    localparam int LINE_LOW_VOLTAGE = 2;
    // compatible mode
    localparam int LINE_C_TIMER_STOP = 3;
    localparam int LINE_C_EXT_LO = 4;
    localparam int LINE_C_EXT_HI = 5;
    localparam int LINE_C_DTQD = 6;
    localparam int LINE_C_SERIAL_BASE = 7;
    localparam int NUM_C_SERIAL_LINES = 13;
    // relocated mode
    localparam int LINE_R_SEL_A_BASE = 3;
    localparam int LINE_R_SEL_B_BASE = 7;
    localparam int LINE_R_TIMER0_SER8 = 11;
    localparam int LINE_R_EXT_LO = 12;
    localparam int LINE_R_EXT_HI = 13;
    localparam int LINE_R_DTQD0 = 14;
    localparam int LINE_R_SERIAL_BASE = 15;
    localparam int NUM_R_SERIAL_LINES = 4;
    localparam int LINE_R_SER4_RX = 19;
    localparam int R_SER8_CH = 8;
    localparam int R_SER_RX_ONLY_CH = 4;

    localparam int EXT_LO_TOP = 7;
    localparam int EXT_HI_LOW = 8;

    localparam logic MODE_COMPATIBLE = 1'h0;
    localparam logic MODE_RELOCATED = 1'h1;
    localparam logic [NUM_LINES-1:0] IRQ_RESET = 20'h00000;

    typedef struct packed {
        logic clock_anomaly_detector;
        logic sw_watchdog;
        logic low_voltage_detector;
        logic [NUM_TIMER_UNITS-1:0] multi_function_timer_wfg;
        logic [NUM_TIMER_UNITS-1:0] motor_emergency_stop_input;
        logic [NUM_EXT_INT-1:0] ext_pin;
        logic [NUM_DTQD-1:0] dual_timer_quadrature_position_counter;
        logic [NUM_SERIAL-1:0] multi_function_serial_rx;
        logic [NUM_SERIAL-1:0] multi_function_serial_tx_status;
    } irqrm_src_t;

    function automatic int irqrm_line_vector(input int line);
        return line + VECTOR_OFFSET;
    endfunction

endpackage

// ---- src/irqrm_mux_top.sv ----
`timescale 1ns/10ps
// Functional notes
// [RL1] mode select 0 gives the compatible mapping and 1 the relocated one, if the variant has it.
// [RL2] vectors 0 to 15 are fixed system exceptions in both modes and own no request line.
// [RL3] line n is vector n+16; lines 0, 1, 2 carry clock anomaly, software watchdog, low voltage.
// [RL4] relocated lines 3 to 6 each follow a source picked by the first source select.
// [RL5] relocated lines 7 to 10 each follow a source picked by the second source select.
// [RL6] compatible line 3 is the waveform and emergency stop requests of all three timer units.
// [RL7] pin interrupts 0-7 and 8-31 use lines 4 and 5 when compatible, 12 and 13 when relocated.
// [RL8] compatible line 6 is dual timer and counters 0-2; relocated line 14 is only counter 0.
// [RL9] compatible lines 7 to 19 alternate receive and transmit/status of serial k with k+8.
// [RL10] relocated line 11 is timer unit 0 stop requests plus all requests of serial channel 8.
// [RL11] relocated lines 15 to 18 carry all requests of serial channels 0 to 3 in order.
// [RL12] relocated line 19 is only the receive request of serial channel 4.
// [RL13] a shared line is high while any of its sources requests and low only when all are idle.
module irqrm_mux_top #(
    parameter bit RELOC_AVAILABLE = 1'b1,
    parameter int SEL_W = irqrm_pkg::SEL_SRC_W,
    parameter int IDX_W = $clog2(irqrm_pkg::SEL_SRC_W)
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire irqrm_pkg::irqrm_src_t src,
    input wire logic [SEL_W-1:0] sel_src,
    input wire logic relocation_mode_select,
    input wire logic [irqrm_pkg::NUM_SEL_FIELDS-1:0][IDX_W-1:0] relocation_source_select_a,
    input wire logic [irqrm_pkg::NUM_SEL_FIELDS-1:0][IDX_W-1:0] relocation_source_select_b,
    output logic [irqrm_pkg::NUM_LINES-1:0] irq_line
);
    import irqrm_pkg::*;

    logic [NUM_LINES-1:0] irq_reg;
    logic [NUM_LINES-1:0] irq_next;
    logic mode_eff;
    logic [NUM_C_SERIAL_LINES-1:0] compat_serial;
    logic [NUM_R_SERIAL_LINES-1:0] reloc_serial;
    logic [NUM_TIMER_UNITS-1:0] timer_stop;

    // variant without relocation stays compatible
    assign mode_eff = RELOC_AVAILABLE ? relocation_mode_select : MODE_COMPATIBLE; // RL1
    assign timer_stop = src.multi_function_timer_wfg | src.motor_emergency_stop_input;

    // compatible serial pairs k and k+8
    for (genvar j = 0; j < 7; j++) begin : g_compat_rx
        assign compat_serial[2*j] = src.multi_function_serial_rx[j]
            | src.multi_function_serial_rx[j+SERIAL_PAIR_STEP]; // RL9 RL13
    end
    for (genvar j = 0; j < 6; j++) begin : g_compat_tx
        assign compat_serial[2*j+1] = src.multi_function_serial_tx_status[j]
            | src.multi_function_serial_tx_status[j+SERIAL_PAIR_STEP]; // RL9 RL13
    end

    // relocated single serial channels
    for (genvar j = 0; j < NUM_R_SERIAL_LINES; j++) begin : g_reloc_ser
        assign reloc_serial[j] = src.multi_function_serial_rx[j]
            | src.multi_function_serial_tx_status[j]; // RL11 RL13
    end

    always_comb begin
        irq_next = IRQ_RESET;
        // vectors 0..15 are core exceptions, never driven here
        irq_next[LINE_CLK_ANOMALY] = src.clock_anomaly_detector; // RL3
        irq_next[LINE_SW_WDOG] = src.sw_watchdog; // RL3
        irq_next[LINE_LOW_VOLTAGE] = src.low_voltage_detector; // RL3
        if (mode_eff == MODE_COMPATIBLE) begin // RL1
            irq_next[LINE_C_TIMER_STOP] = |timer_stop; // RL6 RL13
            irq_next[LINE_C_EXT_LO] = |src.ext_pin[EXT_LO_TOP:0]; // RL7
            irq_next[LINE_C_EXT_HI] = |src.ext_pin[NUM_EXT_INT-1:EXT_HI_LOW]; // RL7
            irq_next[LINE_C_DTQD] = |src.dual_timer_quadrature_position_counter; // RL8
            for (int i = 0; i < NUM_C_SERIAL_LINES; i++) begin
                irq_next[LINE_C_SERIAL_BASE+i] = compat_serial[i]; // RL9
            end
        end else begin
            for (int i = 0; i < NUM_SEL_FIELDS; i++) begin
                irq_next[LINE_R_SEL_A_BASE+i] = sel_src[relocation_source_select_a[i]]; // RL4
                irq_next[LINE_R_SEL_B_BASE+i] = sel_src[relocation_source_select_b[i]]; // RL5
            end
            irq_next[LINE_R_TIMER0_SER8] = timer_stop[0]
                | src.multi_function_serial_rx[R_SER8_CH]
                | src.multi_function_serial_tx_status[R_SER8_CH]; // RL10 RL13
            irq_next[LINE_R_EXT_LO] = |src.ext_pin[EXT_LO_TOP:0]; // RL7
            irq_next[LINE_R_EXT_HI] = |src.ext_pin[NUM_EXT_INT-1:EXT_HI_LOW]; // RL7
            irq_next[LINE_R_DTQD0] = src.dual_timer_quadrature_position_counter[0]; // RL8
            for (int i = 0; i < NUM_R_SERIAL_LINES; i++) begin
                irq_next[LINE_R_SERIAL_BASE+i] = reloc_serial[i]; // RL11
            end
            irq_next[LINE_R_SER4_RX] = src.multi_function_serial_rx[R_SER_RX_ONLY_CH]; // RL12
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_reg <= IRQ_RESET;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign irq_line = irq_reg;

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    sequence s_compat_cycle;
        !srst && !mode_eff;
    endsequence

    sequence s_reloc_cycle;
        !srst && mode_eff;
    endsequence

    property p_mode_variant;
        !RELOC_AVAILABLE |-> !mode_eff;
    endproperty
    a_mode_variant: assert property (p_mode_variant) // RL1
        else $error("relocation active on variant without it");

    property p_vector_map;
        irqrm_line_vector(LINE_LOW_VOLTAGE) == VEC_SYSTEM_TICK_TIMER + 3;
    endproperty
    a_vector_map: assert property (p_vector_map) // RL2
        else $error("line to vector offset broken");

    property p_fixed_lines;
        !srst |=> irq_line[2:0] == {$past(src.low_voltage_detector),
            $past(src.sw_watchdog), $past(src.clock_anomaly_detector)};
    endproperty
    a_fixed_lines: assert property (p_fixed_lines) // RL3
        else $error("lines 0 to 2 wrong");

    property p_sel_a;
        s_reloc_cycle |=> irq_line[LINE_R_SEL_A_BASE+1]
            == $past(sel_src[relocation_source_select_a[1]]);
    endproperty
    a_sel_a: assert property (p_sel_a) // RL4
        else $error("line 4 not following select a");

    property p_sel_b;
        s_reloc_cycle |=> irq_line[LINE_R_SEL_B_BASE+3]
            == $past(sel_src[relocation_source_select_b[3]]);
    endproperty
    a_sel_b: assert property (p_sel_b) // RL5
        else $error("line 10 not following select b");

    property p_compat_timer;
        s_compat_cycle |=> irq_line[LINE_C_TIMER_STOP] == $past(|timer_stop);
    endproperty
    a_compat_timer: assert property (p_compat_timer) // RL6
        else $error("line 3 compatible wrong");

    property p_ext_move;
        s_reloc_cycle ##0 (|src.ext_pin[EXT_LO_TOP:0]) |=> irq_line[LINE_R_EXT_LO]
            && !irq_line[LINE_C_EXT_LO] == !$past(sel_src[relocation_source_select_a[1]]);
    endproperty
    a_ext_move: assert property (p_ext_move) // RL7
        else $error("pin group 0-7 not moved to line 12");

    property p_dtqd;
        s_reloc_cycle |=> irq_line[LINE_R_DTQD0]
            == $past(src.dual_timer_quadrature_position_counter[0]);
    endproperty
    a_dtqd: assert property (p_dtqd) // RL8
        else $error("line 14 wrong");

    property p_compat_serial;
        s_compat_cycle |=> irq_line[19] == $past(src.multi_function_serial_rx[6]
            | src.multi_function_serial_rx[14]) && irq_line[8] == $past(
            src.multi_function_serial_tx_status[0] | src.multi_function_serial_tx_status[8]);
    endproperty
    a_compat_serial: assert property (p_compat_serial) // RL9
        else $error("compatible serial lines wrong");

    property p_line11;
        s_reloc_cycle ##0 src.multi_function_serial_tx_status[R_SER8_CH]
            |=> irq_line[LINE_R_TIMER0_SER8];
    endproperty
    a_line11: assert property (p_line11) // RL10
        else $error("line 11 missed serial 8");

    property p_reloc_serial;
        s_reloc_cycle |=> irq_line[LINE_R_SERIAL_BASE+3] == $past(
            src.multi_function_serial_rx[3] | src.multi_function_serial_tx_status[3]);
    endproperty
    a_reloc_serial: assert property (p_reloc_serial) // RL11
        else $error("line 18 wrong");

    property p_line19;
        s_reloc_cycle |=> irq_line[LINE_R_SER4_RX] == $past(src.multi_function_serial_rx[4]);
    endproperty
    a_line19: assert property (p_line19) // RL12
        else $error("line 19 relocated wrong");

    property p_shared_idle;
        s_compat_cycle ##0 (timer_stop == '0) ##1 s_compat_cycle ##0 (timer_stop == '0)
            |-> !irq_line[LINE_C_TIMER_STOP] ##1 !irq_line[LINE_C_TIMER_STOP];
    endproperty
    a_shared_idle: assert property (p_shared_idle) // RL13
        else $error("shared line high while idle");

    sequence s_switch_to_compat;
        s_reloc_cycle ##1 s_compat_cycle;
    endsequence

    property p_mode_switch;
        s_switch_to_compat |=> irq_line[LINE_C_EXT_LO]
            == $past(|src.ext_pin[EXT_LO_TOP:0]);
    endproperty
    a_mode_switch: assert property (p_mode_switch) // RL1
        else $error("mode change not taken at next edge");

    property p_reset_clear;
        @(posedge clk_sys) disable iff (1'b0)
            srst |=> irq_line == IRQ_RESET;
    endproperty
    a_reset_clear: assert property (p_reset_clear) // RL3
        else $error("lines not cleared by reset");

    for (genvar i = 0; i < NUM_SEL_FIELDS; i++) begin : g_chk_sel
        property p_sel_field;
            s_reloc_cycle |=> irq_line[LINE_R_SEL_A_BASE+i]
                == $past(sel_src[relocation_source_select_a[i]])
                && irq_line[LINE_R_SEL_B_BASE+i]
                == $past(sel_src[relocation_source_select_b[i]]);
        endproperty
        a_sel_field: assert property (p_sel_field) // RL4 RL5
            else $error("selected line not following its field");
    end

    property p_ext_hi_compat;
        s_compat_cycle |=> irq_line[LINE_C_EXT_HI]
            == $past(|src.ext_pin[NUM_EXT_INT-1:EXT_HI_LOW]);
    endproperty
    a_ext_hi_compat: assert property (p_ext_hi_compat) // RL7
        else $error("line 5 compatible wrong");

    property p_ext_hi_reloc;
        s_reloc_cycle |=> irq_line[LINE_R_EXT_HI]
            == $past(|src.ext_pin[NUM_EXT_INT-1:EXT_HI_LOW]);
    endproperty
    a_ext_hi_reloc: assert property (p_ext_hi_reloc) // RL7
        else $error("line 13 relocated wrong");

    property p_compat_dtqd;
        s_compat_cycle |=> irq_line[LINE_C_DTQD]
            == $past(|src.dual_timer_quadrature_position_counter);
    endproperty
    a_compat_dtqd: assert property (p_compat_dtqd) // RL8
        else $error("line 6 compatible wrong");

    for (genvar j = 0; j < 7; j++) begin : g_chk_compat_rx
        property p_compat_rx;
            s_compat_cycle |=> irq_line[LINE_C_SERIAL_BASE+2*j] == $past(
                src.multi_function_serial_rx[j]
                | src.multi_function_serial_rx[j+SERIAL_PAIR_STEP]);
        endproperty
        a_compat_rx: assert property (p_compat_rx) // RL9
            else $error("compatible receive line wrong");
    end

    for (genvar j = 0; j < 6; j++) begin : g_chk_compat_tx
        property p_compat_tx;
            s_compat_cycle |=> irq_line[LINE_C_SERIAL_BASE+2*j+1] == $past(
                src.multi_function_serial_tx_status[j]
                | src.multi_function_serial_tx_status[j+SERIAL_PAIR_STEP]);
        endproperty
        a_compat_tx: assert property (p_compat_tx) // RL9
            else $error("compatible transmit line wrong");
    end

    property p_line11_full;
        s_reloc_cycle |=> irq_line[LINE_R_TIMER0_SER8] == $past(
            src.multi_function_timer_wfg[0] | src.motor_emergency_stop_input[0]
            | src.multi_function_serial_rx[R_SER8_CH]
            | src.multi_function_serial_tx_status[R_SER8_CH]);
    endproperty
    a_line11_full: assert property (p_line11_full) // RL10
        else $error("line 11 relocated wrong");

    for (genvar i = 0; i < NUM_R_SERIAL_LINES; i++) begin : g_chk_reloc_ser
        property p_reloc_ser;
            s_reloc_cycle |=> irq_line[LINE_R_SERIAL_BASE+i] == $past(
                src.multi_function_serial_rx[i] | src.multi_function_serial_tx_status[i]);
        endproperty
        a_reloc_ser: assert property (p_reloc_ser) // RL11
            else $error("relocated serial line wrong");
    end

    property p_line19_only;
        s_reloc_cycle ##0 !src.multi_function_serial_rx[R_SER_RX_ONLY_CH]
            |=> !irq_line[LINE_R_SER4_RX];
    endproperty
    a_line19_only: assert property (p_line19_only) // RL12
        else $error("line 19 raised by another source");

    property p_shared_any;
        s_compat_cycle ##0 (|src.ext_pin[NUM_EXT_INT-1:EXT_HI_LOW])
            |=> irq_line[LINE_C_EXT_HI];
    endproperty
    a_shared_any: assert property (p_shared_any) // RL13
        else $error("shared line low while a source requests");

endmodule

// ---- bench/irqrm_core_model.sv ----
`timescale 1ns/10ps
module irqrm_core_model (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [irqrm_pkg::NUM_LINES-1:0] irq_line,
    output int taken_vector
);
    import irqrm_pkg::*;
    // lowest pending line taken, reported as vector number
    always_ff @(posedge clk_sys) begin
        taken_vector <= -1;
        if (!srst) begin
            for (int n = NUM_LINES - 1; n >= 0; n--) begin
                if (irq_line[n] === 1'b1) begin
                    taken_vector <= n + VECTOR_OFFSET;
                end
            end
        end
    end
endmodule

// ---- bench/irq_source_relocation_mux_test.sv ----
`timescale 1ns/10ps
module irq_source_relocation_mux_test;
    import irqrm_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [$bits(irqrm_src_t)-1:0] src_bits = '0;
    logic [31:0] sel_src = '0;
    logic mode = 1'b0;
    logic [3:0][4:0] sel_a = '0;
    logic [3:0][4:0] sel_b = '0;
    logic [NUM_LINES-1:0] irq_line;
    logic [95:0] r;
    int taken_vector;
    int err_count = 0;
    int compares = 0;
    int seed = 20;

    always #2.5 clk_sys = ~clk_sys;

    irqrm_mux_top i_irqrm_mux_top (.clk_sys(clk_sys), .srst(srst), .src(src_bits),
        .sel_src(sel_src), .relocation_mode_select(mode), .relocation_source_select_a(sel_a),
        .relocation_source_select_b(sel_b), .irq_line(irq_line));
    irqrm_core_model i_irqrm_core_model (.clk_sys(clk_sys), .srst(srst),
        .irq_line(irq_line), .taken_vector(taken_vector));

    // expected lines from the source levels, mode and selects
    function automatic logic [NUM_LINES-1:0] map(input irqrm_src_t s, input logic m,
        input logic [31:0] p, input logic [3:0][4:0] a, input logic [3:0][4:0] b);
        logic [NUM_LINES-1:0] e;
        logic [15:0] rx;
        logic [15:0] tx;
        e = '0;
        rx = s.multi_function_serial_rx;
        tx = s.multi_function_serial_tx_status;
        e[0] = s.clock_anomaly_detector;
        e[1] = s.sw_watchdog;
        e[2] = s.low_voltage_detector;
        if (m == MODE_COMPATIBLE) begin
            e[3] = |{s.multi_function_timer_wfg, s.motor_emergency_stop_input};
            e[4] = |s.ext_pin[7:0];
            e[5] = |s.ext_pin[31:8];
            e[6] = |s.dual_timer_quadrature_position_counter;
            for (int j = 0; j < 7; j++) begin
                e[7+2*j] = rx[j] | rx[j+8];
                if (j < 6) begin
                    e[8+2*j] = tx[j] | tx[j+8];
                end
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                e[3+i] = p[a[i]];
                e[7+i] = p[b[i]];
                e[15+i] = rx[i] | tx[i];
            end
            e[11] = s.multi_function_timer_wfg[0] | s.motor_emergency_stop_input[0]
                | rx[8] | tx[8];
            e[12] = |s.ext_pin[7:0];
            e[13] = |s.ext_pin[31:8];
            e[14] = s.dual_timer_quadrature_position_counter[0];
            e[19] = rx[4];
        end
        return e;
    endfunction

    task automatic check(input logic [NUM_LINES-1:0] seen, input logic [NUM_LINES-1:0] want);
        compares++;
        if (seen !== want) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    // one edge, then compare against the inputs held before it
    task automatic cycle;
        logic [NUM_LINES-1:0] want;
        want = map(src_bits, mode, sel_src, sel_a, sel_b);
        @(posedge clk_sys);
        #1;
        check(irq_line, want);
    endtask

    task automatic give_verdict;
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #50000;
        err_count++;
        give_verdict();
    end

    initial begin
        src_bits = '1;
        repeat (4) @(posedge clk_sys);
        #1;
        check(irq_line, IRQ_RESET);
        srst = 1'b0;
        src_bits = '0;
        $display("test reset done");
        for (int m = 0; m < 2; m++) begin
            mode = m[0];
            for (int k = 0; k < $bits(irqrm_src_t); k++) begin
                src_bits = '0;
                src_bits[k] = 1'b1;
                cycle();
            end
        end
        $display("test single sources done");
        mode = MODE_COMPATIBLE;
        src_bits = '0;
        src_bits[$bits(irqrm_src_t)-38] = 1'b1;
        cycle();
        cycle();
        check(taken_vector[NUM_LINES-1:0], 20'h00014);
        $display("test core vector done");
        for (int n = 0; n < 600; n++) begin
            r = {$random(seed), $random(seed), $random(seed)};
            r = r & {$random(seed), $random(seed), $random(seed)};
            src_bits = r[$bits(irqrm_src_t)-1:0];
            sel_src = $random(seed);
            sel_a = 20'($random(seed));
            sel_b = 20'($random(seed));
            mode = 1'($random(seed));
            cycle();
        end
        $display("test random done");
        src_bits = '1;
        srst = 1'b1;
        @(posedge clk_sys);
        #1;
        check(irq_line, IRQ_RESET);
        srst = 1'b0;
        cycle();
        $display("test mid reset done");
        give_verdict();
    end
endmodule
